/* File: verilog/arb_pkg.sv */
package arb_pkg;

  // ----------------------------------------------------------------
  // Register offsets, byte addresses within the converter block
  // ----------------------------------------------------------------
  localparam logic [4:0] ARB_OFS_STATUS  = 5'h00;
  localparam logic [4:0] ARB_OFS_CTRL_A  = 5'h02;
  localparam logic [4:0] ARB_OFS_CTRL_B  = 5'h04;
  localparam logic [4:0] ARB_OFS_CTRL_C  = 5'h06;
  localparam logic [4:0] ARB_OFS_SLOT0   = 5'h08;
  localparam logic [4:0] ARB_OFS_SLOT1   = 5'h0a;
  localparam logic [4:0] ARB_OFS_SLOT2   = 5'h0c;
  localparam logic [4:0] ARB_OFS_SLOT3   = 5'h0e;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int ARB_ST_EOC_BIT    = 0;
  localparam int ARB_ST_BUSY_BIT   = 1;
  localparam int ARB_ST_OVR_BIT    = 2;
  localparam int ARB_ST_PTR_LSB    = 4;
  localparam int ARB_CA_EN_BIT     = 0;
  localparam int ARB_CA_IRQ_BIT    = 2;
  localparam int ARB_CB_CHAN_LSB   = 0;
  localparam int ARB_CB_REPEAT_BIT = 4;
  localparam int ARB_CB_SCAN_LSB   = 5;
  localparam int ARB_CB_START_BIT  = 7;
  localparam int ARB_CC_CLOCK_DIVIDE_FIELD_LSB   = 0;
  localparam int ARB_CC_DELAY_LSB  = 3;

  // ----------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------
  localparam logic [1:0] ARB_PTR_RESET  = 2'h3;
  localparam logic [1:0] ARB_SCAN_FOUR  = 2'h1;
  localparam logic [3:0] ARB_CONV_TICKS = 4'ha;
  localparam logic [1:0] ARB_LAST_SCAN  = 2'h3;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {ARB_IDLE, ARB_SETTLE, ARB_CONVERT} arb_state_type;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic        byte_size;
    logic [4:0]  addr;
    logic [15:0] wdata;
  } arb_bus_req_type;

  // Reserved codes 110 and 111 fall back to the slowest rate.
  function automatic logic [4:0] arb_div_limit(input logic [2:0] clock_divide_field);
    logic [2:0] c;
    c = (clock_divide_field > 3'h5) ? 3'h5 : clock_divide_field;
    return 5'((6'h01 << c) - 6'h01);
  endfunction

  // Reserved code 111 is treated as 64 ticks.
  function automatic logic [6:0] arb_delay_limit(input logic [2:0] dly);
    logic [2:0] d;
    d = (dly > 3'h6) ? 3'h6 : dly;
    return 7'((8'h01 << d) - 8'h01);
  endfunction

  // Scan visits four channels of the group holding the programmed one.
  function automatic logic [2:0] arb_scan_chan(input logic [3:0] chan,
                                               input logic       scan,
                                               input logic [1:0] idx);
    return scan ? {chan[2], idx} : chan[2:0];
  endfunction

endpackage

/* File: verilog/arb_clk_div.sv */
`timescale 1ns/10ps
module arb_clk_div (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  // Control
  input  wire logic       run_in,
  input  wire logic [2:0] clock_divide_field_in,
  // Converter tick
  output logic            tick_out
);
  import arb_pkg::*;

  typedef struct packed {
    logic [4:0] cnt;
    logic       tick;
  } arb_div_type;

  arb_div_type div_reg;
  arb_div_type div_next;

  // The count restarts with every run so the first tick has a fixed phase.
  always_comb begin
    div_next = div_reg;
    if (!run_in) begin
      div_next.cnt  = 5'h00;
      div_next.tick = 1'b0;
    end else if (div_reg.cnt >= arb_div_limit(clock_divide_field_in)) begin
      div_next.cnt  = 5'h00;
      div_next.tick = 1'b1;
    end else begin
      div_next.cnt  = div_reg.cnt + 5'h01;
      div_next.tick = 1'b0;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_next;
    end
  end

  assign tick_out = div_reg.tick;

endmodule

/* File: verilog/arb_top.sv */
`timescale 1ns/10ps
// Summary of operation
// - Four byte result slots are filled in order, slot zero first, slot three last.
// - Result slots need no defined value after reset.
// - Results are unsigned 8-bit codes, 00 is zero volts, ff is reference.
// - Converter rate is system clock divided by 1, 2, 4, 8, 16 or 32.
// - A conversion lasts ten converter clock periods.
// - The interrupt output is raised only while the interrupt enable bit is set.
// - Reading any result slot clears the pending interrupt.
// - One control write sets mode, channel and start, and begins the cycle.
// - Single-channel single conversion writes only slot zero.
// - Continuous operation stops when start or enable is cleared.
// - Byte registers take one address and accept only byte transactions.
// - Word registers take two addresses and accept only word transactions.
// - Registers sit at even addresses, byte data on the low eight bus bits.
// - Reserved bits may read as any value.
// - End-of-conversion sets when results are stored, clears on a slot read.
// - Pointer loads 11 at start, advances per result, marks newest slot.
// - Clearing enable aborts and clears end, busy, overrun and start.
// - Without repeat the start bit clears itself when the cycle ends.
module arb_top (
  // Clock and reset
  input  wire logic                     clk_in,
  input  wire logic                     rst_in,
  // Register bus
  input  wire arb_pkg::arb_bus_req_type bus_req_in,
  output logic [15:0]                   bus_rdata_out,
  // Conversion core
  input  wire logic [7:0]               core_result_in,
  output logic [2:0]                    core_channel_out,
  output logic                          core_sample_out,
  output logic                          core_power_out,
  // Status
  output logic                          busy_out,
  output logic                          irq_out
);
  import arb_pkg::*;

  typedef struct packed {
    arb_state_type   st;
    logic            en;
    logic            irq_enable_bit;
    logic            start;
    logic [1:0]      scan;
    logic            repeat_sel;
    logic [3:0]      chan;
    logic [2:0]      dly;
    logic [2:0]      clock_divide_field;
    logic [1:0]      ptr;
    logic            eoc;
    logic            ovr;
    logic            pend;
    logic [3:0]      full;
    logic [3:0][7:0] slot;
    logic [1:0]      idx;
    logic [6:0]      cnt;
    logic [15:0]     rdata;
    logic [2:0]      chan_out;
    logic            sample;
    logic            busy;
    logic            irq;
  } arb_regs_type;

  arb_regs_type r_reg;
  arb_regs_type r_next;
  logic         tick;

  arb_clk_div u_div (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .run_in   (r_reg.busy),
    .clock_divide_field_in  (r_reg.clock_divide_field),
    .tick_out (tick)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic       acc_ok;
    logic       wr;
    logic       rd;
    logic [7:0] wd;
    logic       abort;
    logic       halt;
    logic       slot_sel;
    logic [1:0] sidx;
    logic [1:0] np;
    logic       last;
    acc_ok   = 1'b0;
    wr       = 1'b0;
    rd       = 1'b0;
    wd       = 8'h00;
    abort    = 1'b0;
    halt     = 1'b0;
    slot_sel = 1'b0;
    sidx     = 2'h0;
    np       = 2'h0;
    last     = 1'b0;
    r_next        = r_reg;
    r_next.sample = 1'b0;

    // no word registers here, so word transactions are refused
    // only byte transactions at even addresses are taken
    acc_ok   = bus_req_in.byte_size & ~bus_req_in.addr[0];
    wr       = bus_req_in.wr & acc_ok;
    rd       = bus_req_in.rd & acc_ok;
    // byte registers use the low eight data bits
    wd       = bus_req_in.wdata[7:0];
    slot_sel = bus_req_in.addr[4:3] == ARB_OFS_SLOT0[4:3];
    sidx     = bus_req_in.addr[2:1];

    // read data comes from the state before this cycle's result write
    if (rd) begin
      r_next.rdata = 16'h0000;
      if (slot_sel) begin
        r_next.rdata[7:0] = r_reg.slot[sidx];
        r_next.eoc        = 1'b0;
        r_next.pend       = 1'b0;
        r_next.full[sidx] = 1'b0;
      end else begin
        unique case (bus_req_in.addr)
          ARB_OFS_STATUS: begin
            r_next.rdata[ARB_ST_EOC_BIT]  = r_reg.eoc;
            r_next.rdata[ARB_ST_BUSY_BIT] = r_reg.busy;
            r_next.rdata[ARB_ST_OVR_BIT]  = r_reg.ovr;
            r_next.rdata[ARB_ST_PTR_LSB +: 2] = r_reg.ptr;
          end
          ARB_OFS_CTRL_A: begin
            r_next.rdata[ARB_CA_EN_BIT]  = r_reg.en;
            r_next.rdata[ARB_CA_IRQ_BIT] = r_reg.irq_enable_bit;
          end
          ARB_OFS_CTRL_B: begin
            r_next.rdata[ARB_CB_START_BIT]     = r_reg.start;
            r_next.rdata[ARB_CB_SCAN_LSB +: 2] = r_reg.scan;
            r_next.rdata[ARB_CB_REPEAT_BIT]    = r_reg.repeat_sel;
            r_next.rdata[ARB_CB_CHAN_LSB +: 4] = r_reg.chan;
          end
          ARB_OFS_CTRL_C: begin
            r_next.rdata[ARB_CC_CLOCK_DIVIDE_FIELD_LSB +: 3]  = r_reg.clock_divide_field;
            r_next.rdata[ARB_CC_DELAY_LSB +: 3] = r_reg.dly;
          end
          default: r_next.rdata = 16'h0000;
        endcase
      end
    end

    if (wr) begin
      if (slot_sel) begin
        r_next.slot[sidx] = wd;
      end else begin
        unique case (bus_req_in.addr)
          ARB_OFS_STATUS: begin
            if (wd[ARB_ST_OVR_BIT]) begin
              r_next.ovr = 1'b0;
            end
          end
          ARB_OFS_CTRL_A: begin
            r_next.irq_enable_bit = wd[ARB_CA_IRQ_BIT];
            r_next.en   = wd[ARB_CA_EN_BIT];
            if (!wd[ARB_CA_EN_BIT]) begin
              abort = 1'b1;
            end
          end
          ARB_OFS_CTRL_B: begin
            r_next.chan = wd[ARB_CB_CHAN_LSB +: 4];
            if (!r_reg.start) begin
              r_next.scan       = wd[ARB_CB_SCAN_LSB +: 2];
              r_next.repeat_sel = wd[ARB_CB_REPEAT_BIT];
            end
            // one write selects mode and channel and starts
            if (!r_reg.start && wd[ARB_CB_START_BIT] && r_reg.en) begin
              r_next.start    = 1'b1;
              r_next.ptr      = ARB_PTR_RESET;
              r_next.idx      = 2'h0;
              r_next.cnt      = 7'h00;
              r_next.st       = ARB_SETTLE;
              r_next.chan_out = arb_scan_chan(wd[ARB_CB_CHAN_LSB +: 4],
                                              wd[ARB_CB_SCAN_LSB +: 2] == ARB_SCAN_FOUR,
                                              2'h0);
            end else if (r_reg.start && !wd[ARB_CB_START_BIT]) begin
              halt         = 1'b1;
              r_next.start = 1'b0;
              r_next.st    = ARB_IDLE;
            end
          end
          ARB_OFS_CTRL_C: begin
            r_next.clock_divide_field = wd[ARB_CC_CLOCK_DIVIDE_FIELD_LSB +: 3];
            r_next.dly  = wd[ARB_CC_DELAY_LSB +: 3];
          end
          default: r_next.cnt = r_next.cnt;
        endcase
      end
    end

    // Sequencer events come after software clears so that a set wins.
    // A stop write in a tick cycle must not be undone by the sequencer, or it would run on.
    if (tick && !abort && !halt) begin
      unique case (r_reg.st)
        ARB_IDLE: r_next.cnt = 7'h00;
        ARB_SETTLE: begin
          if (r_reg.cnt >= arb_delay_limit(r_reg.dly)) begin
            r_next.sample = 1'b1;
            r_next.cnt    = 7'h00;
            r_next.st     = ARB_CONVERT;
          end else begin
            r_next.cnt = r_reg.cnt + 7'h01;
          end
        end
        ARB_CONVERT: begin
          if (r_reg.cnt >= 7'(ARB_CONV_TICKS - 4'h1)) begin
            np = r_reg.ptr + 2'h1;
            r_next.slot[np] = core_result_in;
            if (r_next.full[np]) begin
              r_next.ovr = 1'b1;
            end
            r_next.full[np] = 1'b1;
            r_next.ptr      = np;
            r_next.cnt      = 7'h00;
            last = (r_reg.scan != ARB_SCAN_FOUR) || (r_reg.idx == ARB_LAST_SCAN);
            r_next.idx = (r_reg.scan == ARB_SCAN_FOUR) ? r_reg.idx + 2'h1 : 2'h0;
            if (last) begin
              // end flag sets on stored results
              r_next.eoc  = 1'b1;
              r_next.pend = 1'b1;
            end
            if (r_reg.repeat_sel || !last) begin
              r_next.st       = ARB_SETTLE;
              r_next.chan_out = arb_scan_chan(r_reg.chan, r_reg.scan == ARB_SCAN_FOUR,
                                              r_next.idx);
            end else begin
              // start clears at end of cycle
              // single mode stops after slot zero, or after slot three when scanning
              r_next.start = 1'b0;
              r_next.st    = ARB_IDLE;
            end
          end else begin
            r_next.cnt = r_reg.cnt + 7'h01;
          end
        end
        default: r_next.st = ARB_IDLE;
      endcase
    end

    if (abort) begin
      r_next.st     = ARB_IDLE;
      r_next.start  = 1'b0;
      r_next.eoc    = 1'b0;
      r_next.ovr    = 1'b0;
      r_next.pend   = 1'b0;
      r_next.sample = 1'b0;
    end

    r_next.busy = r_next.st != ARB_IDLE;
    r_next.irq  = r_next.pend & r_next.irq_enable_bit;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      // slots cleared anyway, software must not rely on it
      r_reg     <= '0;
      r_reg.st  <= ARB_IDLE;
      r_reg.ptr <= ARB_PTR_RESET;
    end else begin
      r_reg <= r_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign bus_rdata_out    = r_reg.rdata;
  assign core_channel_out = r_reg.chan_out;
  assign core_sample_out  = r_reg.sample;
  assign core_power_out   = r_reg.en;
  assign busy_out         = r_reg.busy;
  assign irq_out          = r_reg.irq;

endmodule

/* File: tb/arb_core_model.sv */
`timescale 1ns/10ps
module arb_core_model (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  // Code the bench wants converted
  input  wire logic [4:0] code_in,
  // Converter control
  input  wire logic [2:0] channel_in,
  input  wire logic       sample_in,
  input  wire logic       power_in,
  // Result
  output logic [7:0]      result_out
);
  logic [7:0] held_reg;

  // Unpowered, the comparator output is junk, so it toggles to expose early stores.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in)
      held_reg <= 8'h00;
    else if (!power_in)
      held_reg <= ~held_reg;
    else if (sample_in)
      held_reg <= {code_in, channel_in};
  end

  assign result_out = held_reg;
endmodule

/* File: tb/arb_top_checker.sv */
`timescale 1ns/10ps
module arb_top_checker (
  // Clock and reset
  input wire logic                     clk_in,
  input wire logic                     rst_in,
  // Watched ports
  input wire arb_pkg::arb_bus_req_type bus_req_in,
  input wire logic [15:0]              bus_rdata_out,
  input wire logic [7:0]               core_result_in,
  input wire logic [2:0]               core_channel_out,
  input wire logic                     core_sample_out,
  input wire logic                     core_power_out,
  input wire logic                     busy_out,
  input wire logic                     irq_out
);
  import arb_pkg::*;
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);

  arb_bus_req_type q;
  logic            rd_ok;
  logic            wr_a;
  logic            ien_reg;
  logic            ien_next;

  assign q     = bus_req_in;
  assign rd_ok = q.rd && q.byte_size && !q.addr[0];
  assign wr_a  = q.wr && q.byte_size && q.addr == ARB_OFS_CTRL_A;

  // Shadow of the interrupt enable, since the port list does not show it.
  always_comb ien_next = wr_a ? q.wdata[ARB_CA_IRQ_BIT] : ien_reg;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in)
      ien_reg <= 1'b0;
    else
      ien_reg <= ien_next;
  end

  chk_irq_gated: assert property (irq_out |-> ien_reg || $past(ien_reg))
    else $error("irq raised while disabled");
  chk_power_follows: assert property (wr_a |-> ##2 core_power_out ==
    $past(q.wdata[ARB_CA_EN_BIT], 2)) else $error("power not following enable");
  chk_disable_stops: assert property (wr_a && !q.wdata[ARB_CA_EN_BIT]
    |=> ##1 !busy_out && !irq_out) else $error("disable did not stop");
  chk_slot_read_irq: assert property (rd_ok && q.addr[4:3] == 2'h1 && !busy_out
    |=> !irq_out) else $error("slot read left irq");
  chk_sample_busy: assert property (core_sample_out |-> busy_out && core_power_out)
    else $error("sample while idle");
  chk_start_busy: assert property (q.wr && q.byte_size && q.addr == ARB_OFS_CTRL_B
    && q.wdata[ARB_CB_START_BIT] && core_power_out && !busy_out |=> busy_out)
    else $error("start did not raise busy");
  chk_sample_gap: assert property (core_sample_out |=> !core_sample_out [*8])
    else $error("samples too close");
  chk_rdata_high: assert property (rd_ok |=> bus_rdata_out[15:8] == 8'h00)
    else $error("upper read bits set");
  chk_word_ignored: assert property (q.rd && (!q.byte_size || q.addr[0])
    |=> $stable(bus_rdata_out)) else $error("refused read changed data");

  cover property (core_sample_out);
  cover property ($rose(irq_out));
  cover property ($fell(busy_out));
endmodule

bind arb_top arb_top_checker u_arb_top_checker (.clk_in(clk_in), .rst_in(rst_in),
  .bus_req_in(bus_req_in), .bus_rdata_out(bus_rdata_out),
  .core_result_in(core_result_in), .core_channel_out(core_channel_out),
  .core_sample_out(core_sample_out), .core_power_out(core_power_out),
  .busy_out(busy_out), .irq_out(irq_out));

/* File: tb/testbench.sv */
`timescale 1ns/10ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin fails++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end
module testbench;
  import arb_pkg::*;
  logic            clk_in = 1'b0;
  logic            rst_in = 1'b1;
  arb_bus_req_type bus_req = '0;
  logic [15:0]     rdata;
  logic [15:0]     got = 16'h0000;
  logic [7:0]      result;
  logic [7:0]      rnd = 8'h4f;
  logic [4:0]      code = 5'h00;
  logic [2:0]      chan;
  logic [2:0]      ch;
  logic            sample, power, busy, irq;
  int              fails = 0, tests_run = 0, cyc = 0, samp_cyc = 0, i, k, cd, d;

  arb_top u_arb_top (.clk_in(clk_in), .rst_in(rst_in), .bus_req_in(bus_req),
    .bus_rdata_out(rdata), .core_result_in(result), .core_channel_out(chan),
    .core_sample_out(sample), .core_power_out(power), .busy_out(busy), .irq_out(irq));
  arb_core_model u_arb_core_model (.clk_in(clk_in), .rst_in(rst_in), .code_in(code),
    .channel_in(chan), .sample_in(sample), .power_in(power), .result_out(result));

  always #4 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (sample === 1'b1)
      samp_cyc <= cyc;
  end

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic logic [15:0] slot(input logic [4:0] c, input logic [2:0] n);
    return {8'h00, c, n};
  endfunction

  task automatic conclude();
    if (fails == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic xfer(input logic r, w, b, input logic [4:0] a, input logic [15:0] v);
    @(posedge clk_in);
    bus_req <= '{r, w, b, a, v};
    @(posedge clk_in);
    bus_req.rd <= 1'b0;
    bus_req.wr <= 1'b0;
    #1 got = rdata;
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    xfer(1'b0, 1'b1, 1'b1, a, {8'h00, v});
  endtask
  task automatic rd(input string nm, input logic [4:0] a, input logic [15:0] e);
    xfer(1'b1, 1'b0, 1'b1, a, 16'h0000);
    `CHK(nm, e, got)
  endtask
  task automatic wait_irq();
    int n;
    for (n = 0; n < 9000 && irq !== 1'b1; n++) @(posedge clk_in);
    if (n >= 9000) begin
      fails++;
      conclude();
    end
  endtask
  // Disabled while the rate and delay change, then the settling wait at 125 MHz.
  task automatic setup(input logic [2:0] c, dl);
    wr(ARB_OFS_CTRL_A, 8'h00);
    wr(ARB_OFS_CTRL_C, {2'h0, dl, c});
    wr(ARB_OFS_CTRL_A, 8'h05);
    repeat (12500) @(posedge clk_in);
  endtask

  initial begin
    repeat (12) @(posedge clk_in);
    rst_in <= 1'b0;
    rd("status", ARB_OFS_STATUS, 16'h0030);
    xfer(1'b1, 1'b0, 1'b0, 5'h10, 16'h0000);
    `CHK("word read", 16'h0030, got)
    xfer(1'b0, 1'b1, 1'b0, ARB_OFS_CTRL_C, 16'h0007);
    xfer(1'b0, 1'b1, 1'b1, ARB_OFS_CTRL_C | 5'h01, 16'h0007);
    rd("ctrl c", ARB_OFS_CTRL_C, 16'h0000);
    rd("unmapped", 5'h10, 16'h0000);
    for (cd = 0; cd < 6; cd++) begin
      rnd = lfsr(rnd);
      code <= rnd[7:3];
      ch = rnd[2:0];
      setup(3'(cd), 3'(cd % 3));
      wr(ARB_OFS_CTRL_B, {5'h10, ch});
      `CHK("busy out", 1'b1, busy)
      wait_irq();
      d = cyc - samp_cyc;
      `CHK("convert time", 1'b1, d >= (10 << cd) - 1 && d <= (10 << cd) + 2)
      rd("status done", ARB_OFS_STATUS, 16'h0001);
      rd("start cleared", ARB_OFS_CTRL_B, {13'h0000, ch});
      rd("slot zero", ARB_OFS_SLOT0, slot(code, ch));
      rd("status read", ARB_OFS_STATUS, 16'h0000);
    end
    // Polled scan with the interrupt masked.
    wr(ARB_OFS_CTRL_A, 8'h01);
    wr(ARB_OFS_CTRL_B, {5'h14, ch});
    for (i = 0; i < 2000 && got[0] !== 1'b1; i++) xfer(1'b1, 1'b0, 1'b1, ARB_OFS_STATUS, 0);
    if (i >= 2000) begin
      fails++;
      conclude();
    end
    `CHK("scan status", 16'h0031, got)
    `CHK("masked irq", 1'b0, irq)
    for (k = 0; k < 4; k++)
      rd("scan slot", ARB_OFS_SLOT0 + 5'(2 * k), slot(code, {ch[2], 2'(k)}));
    wr(ARB_OFS_CTRL_A, 8'h05);
    wr(ARB_OFS_CTRL_B, {5'h12, ch});
    wait_irq();
    // Four more results at 448 cycles each without reads, so the fifth overruns slot zero.
    repeat (1800) @(posedge clk_in);
    wr(ARB_OFS_CTRL_B, 8'h00);
    rd("stopped busy", ARB_OFS_STATUS, 16'h0005);
    `CHK("stop flags", 3'h5, got[2:0])
    rd("slot zero", ARB_OFS_SLOT0, slot(code, ch));
    wr(ARB_OFS_CTRL_B, {5'h12, ch});
    wait_irq();
    wr(ARB_OFS_CTRL_A, 8'h04);
    xfer(1'b1, 1'b0, 1'b1, ARB_OFS_STATUS, 0);
    `CHK("disabled flags", 3'h0, got[2:0])
    rd("disabled start", ARB_OFS_CTRL_B, {13'h0002, ch});
    conclude();
  end
endmodule
